// ==== hw/sssp_pkg.sv ====
// constants shared by the serial status and pin mode block
// assumes a 32-bit AXI4-Lite host; registers sit at word index times four
package sssp_pkg;
    // register word indices, byte address is index * 4
    localparam logic [9:0] IDX_CTRL     = 10'h0e7;
    localparam logic [9:0] IDX_STATUS   = 10'h0ea;
    localparam logic [9:0] IDX_PIN_MODE = 10'h0eb;
    localparam logic [9:0] IDX_TX_DATA  = 10'h0ec;
    localparam logic [9:0] IDX_RX_DATA  = 10'h0ed;
    // status flag positions
    localparam int ST_ARB    = 2;
    localparam int ST_NO_ACK = 4;
    localparam int ST_RX     = 5;
    localparam int ST_TX_END_FLAG   = 6;
    localparam int ST_TEMPTY = 7;
    localparam logic [7:0] ST_MASK = 8'hf4;
    // pin mode fields
    localparam int PM_MS     = 0;
    localparam int PM_CS_OD  = 1;
    localparam int PM_DAT_OD = 2;
    localparam int PM_CLK_OD = 3;
    localparam int PM_CSS_LO = 4;
    localparam int PM_CSS_HI = 5;
    localparam int PM_CLKSEL = 6;
    localparam int PM_BIDIR  = 7;
    localparam logic [7:0] PIN_MODE_RESET = 8'h00;
    // control fields
    localparam int CT_TWO_WIRE = 0;
    localparam int CT_TX_DIR   = 1;
    localparam int CT_ACK_CHK  = 2;
    localparam int CT_MASTER   = 3;
    localparam int CT_START    = 4;
    localparam int CT_ACK_BIT  = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // frame shape: last bit counter value
    localparam logic [3:0] SYNC_LAST = 4'h7;
    localparam logic [3:0] TWI_LAST  = 4'h8;
    // synchroniser lanes
    localparam int SY_SCK = 0;
    localparam int SY_SDI = 1;
    localparam int SY_SDO = 2;
    localparam int SY_CS  = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic {SSSP_IDLE, SSSP_SHIFT} sssp_state_t;
endpackage

// ==== hw/sssp_top.sv ====
// serial status flags, pin mode register and a byte shift engine
// assumes AXI4-Lite master on aclk; serial pins are asynchronous to aclk
module sssp_top
    import sssp_pkg::*;
(
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi4-lite write
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // serial pins
    input  wire logic        sck_in,
    input  wire logic        sdi_in,
    input  wire logic        sdo_in,
    output logic             sdo_out,
    output logic             sdo_oe_n,
    input  wire logic        cs_n_in,
    output logic             cs_n_out,
    output logic             cs_oe_n,
    // pad configuration
    output logic             cs_port_mode,
    output logic             cs_input_mode,
    output logic             clk_port_mode,
    output logic             clk_open_drain
);
    sssp_state_t state;
    logic [7:0]  pin_mode;
    logic [7:0]  ctrl;
    logic [7:0]  shift_reg;
    logic [7:0]  tx_data_reg;
    logic [7:0]  rx_data_reg;
    logic [3:0]  bit_cnt;
    logic        tx_buf_full;
    logic        ack_bit;
    logic        cs_started;
    logic        no_ack_flag;
    logic        rx_full_flag;
    logic        tx_end_flag;
    logic        tx_empty_flag;
    logic        arb_lost_overrun_flag;
    logic [7:0]  armed;
    logic [3:0]  sy1;
    logic [3:0]  sy2;
    logic        sck_prev;
    // held write channels
    logic [9:0]  aw_idx;
    logic        aw_held;
    logic [7:0]  w_byte;
    logic        w_en;
    logic        w_held;

    function automatic logic idx_mapped(input logic [9:0] idx);
        return idx == IDX_CTRL || idx == IDX_STATUS || idx == IDX_PIN_MODE
            || idx == IDX_TX_DATA || idx == IDX_RX_DATA;
    endfunction

    logic       wr_go;
    logic       rd_go;
    logic [9:0] rd_idx;
    logic       wr_ctrl;
    logic       wr_status;
    logic       wr_tx;
    logic       rd_rx;
    logic       rd_status;
    logic [7:0] st_now;
    logic [7:0] st_clr;
    logic       two_wire;
    logic       tx_dir;
    logic       bidir_eff;
    logic       din;
    logic       rise;
    logic       bit_step;
    logic       at_last;
    logic       load;
    logic       reload;
    logic       set_arb;
    logic       set_nack;
    logic       set_rx;
    logic       set_ovr;
    logic       set_tx_end_flag;
    logic       set_tempty;
    logic [7:0] rx_byte;
    logic [3:0] frame_last;

    always_comb begin
        wr_go     = aw_held && w_held && !bvalid;
        rd_go     = arvalid && arready;
        rd_idx    = araddr[11:2];
        wr_ctrl   = wr_go && w_en && aw_idx == IDX_CTRL;
        wr_status = wr_go && w_en && aw_idx == IDX_STATUS;
        wr_tx     = wr_go && w_en && aw_idx == IDX_TX_DATA;
        rd_rx     = rd_go && rd_idx == IDX_RX_DATA;
        rd_status = rd_go && rd_idx == IDX_STATUS;
        st_now    = {tx_empty_flag, tx_end_flag, rx_full_flag, no_ack_flag,
                     1'b0, arb_lost_overrun_flag, 2'h0};
        st_clr    = wr_status ? (armed & ~w_byte & ST_MASK) : 8'h00;
        two_wire  = ctrl[CT_TWO_WIRE];
        tx_dir    = ctrl[CT_TX_DIR];
        bidir_eff = pin_mode[PM_MS] && pin_mode[PM_BIDIR];
        din       = (two_wire || bidir_eff) ? sy2[SY_SDO] : sy2[SY_SDI];
        rise      = sy2[SY_SCK] && !sck_prev && pin_mode[PM_CLKSEL];
        frame_last = two_wire ? TWI_LAST : SYNC_LAST;
        bit_step  = rise && (state == SSSP_SHIFT || !tx_dir);
        at_last   = bit_step && bit_cnt == frame_last;
        rx_byte   = two_wire ? shift_reg : {shift_reg[6:0], din};
        set_arb   = bit_step && state == SSSP_SHIFT && two_wire
                    && ctrl[CT_MASTER] && tx_dir && bit_cnt < TWI_LAST
                    && shift_reg[7] && !din;
        set_nack  = at_last && two_wire && tx_dir
                    && ctrl[CT_ACK_CHK] && din;
        set_rx    = at_last && !tx_dir && !rx_full_flag;
        set_ovr   = at_last && !tx_dir && rx_full_flag;
        set_tx_end_flag  = at_last && tx_dir && tx_empty_flag;
        load      = state == SSSP_IDLE && tx_dir && tx_buf_full
                    && pin_mode[PM_CLKSEL];
        reload    = at_last && tx_dir && tx_buf_full && !set_nack;
        set_tempty = load || reload
                    || (wr_ctrl && w_byte[CT_TX_DIR] && !tx_dir)
                    || (wr_ctrl && w_byte[CT_START]);
    end

    // synchroniser: first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sy1      <= 4'h0;
            sy2      <= 4'h0;
            sck_prev <= 1'b0;
        end else if (ce) begin
            sy1      <= {cs_n_in, sdo_in, sdi_in, sck_in};
            sy2      <= sy1;
            sck_prev <= sy2[SY_SCK];
        end
    end

    // axi write side: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_idx  <= 10'h000;
            w_byte  <= 8'h00;
            w_en    <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_idx  <= awaddr[11:2];
                aw_held <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_byte <= wdata[7:0];
                w_en   <= wstrb[0];
                w_held <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_go) begin
                bvalid  <= 1'b1;
                bresp   <= idx_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // axi read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (ce) begin
            if (rd_go) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
                unique case (rd_idx)
                    IDX_CTRL:     rdata <= {24'h0, 2'h0, ack_bit, 1'b0,
                                            ctrl[3:0]};
                    IDX_STATUS:   rdata <= {24'h0, st_now};
                    IDX_PIN_MODE: rdata <= {24'h0, pin_mode};
                    IDX_TX_DATA:  rdata <= {24'h0, tx_data_reg};
                    IDX_RX_DATA:  rdata <= {24'h0, rx_data_reg};
                    default:      rdata <= 32'h0000_0000;
                endcase
            end else if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_mode <= PIN_MODE_RESET;
            ctrl     <= CTRL_RESET;
        end else if (ce) begin
            if (wr_go && w_en && aw_idx == IDX_PIN_MODE)
                pin_mode <= w_byte;
            if (wr_ctrl)
                ctrl <= {4'h0, w_byte[3:0]};
        end
    end

    // status flags: hardware set wins over any clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            no_ack_flag           <= 1'b0;
            rx_full_flag          <= 1'b0;
            tx_end_flag           <= 1'b0;
            tx_empty_flag         <= 1'b0;
            arb_lost_overrun_flag <= 1'b0;
            armed                 <= 8'h00;
        end else if (ce) begin
            no_ack_flag <= set_nack || (no_ack_flag && !st_clr[ST_NO_ACK]);
            rx_full_flag <= set_rx
                || (rx_full_flag && !st_clr[ST_RX] && !rd_rx);
            tx_end_flag <= set_tx_end_flag
                || (tx_end_flag && !st_clr[ST_TX_END_FLAG] && !wr_tx);
            tx_empty_flag <= set_tempty
                || (tx_empty_flag && !st_clr[ST_TEMPTY] && !wr_tx);
            arb_lost_overrun_flag <= set_arb || set_ovr
                || (arb_lost_overrun_flag && !st_clr[ST_ARB]);
            // a read of 1 arms the clear; a status write disarms unless a status read lands in the same cycle
            if (rd_status)
                armed <= armed | (st_now & ST_MASK);
            else if (wr_status)
                armed <= 8'h00;
        end
    end

    // transmit buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_data_reg <= 8'h00;
            tx_buf_full <= 1'b0;
        end else if (ce) begin
            if (wr_tx) begin
                tx_data_reg <= w_byte;
                tx_buf_full <= 1'b1;
            end else if (load || reload) begin
                tx_buf_full <= 1'b0;
            end
        end
    end

    // shift engine, stepped by rising serial clock edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= SSSP_IDLE;
            shift_reg   <= 8'h00;
            bit_cnt     <= 4'h0;
            rx_data_reg <= 8'h00;
            ack_bit     <= 1'b0;
        end else if (ce) begin
            if (set_rx)
                rx_data_reg <= rx_byte;
            unique case (state)
                SSSP_IDLE: begin
                    if (load) begin
                        shift_reg <= tx_data_reg;
                        bit_cnt   <= 4'h0;
                        state     <= SSSP_SHIFT;
                    end else if (bit_step) begin
                        shift_reg <= {shift_reg[6:0], din};
                        bit_cnt   <= 4'h1;
                        state     <= SSSP_SHIFT;
                    end
                end
                SSSP_SHIFT: begin
                    if (set_arb) begin
                        state   <= SSSP_IDLE;
                        bit_cnt <= 4'h0;
                    end else if (at_last) begin
                        if (two_wire)
                            ack_bit <= din;
                        bit_cnt <= 4'h0;
                        if (reload)
                            shift_reg <= tx_data_reg;
                        else
                            state <= SSSP_IDLE;
                    end else if (bit_step) begin
                        shift_reg <= {shift_reg[6:0], din};
                        bit_cnt   <= bit_cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    // data pin: open-drain in two-wire mode or when selected
    logic drv_on;
    logic drv_bit;
    always_comb begin
        drv_on  = state == SSSP_SHIFT
                  && ((tx_dir && bit_cnt < TWI_LAST)
                      || (!tx_dir && two_wire && bit_cnt == TWI_LAST));
        drv_bit = tx_dir ? shift_reg[7] : 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdo_out  <= 1'b1;
            sdo_oe_n <= 1'b1;
        end else if (ce) begin
            if (!drv_on) begin
                sdo_out  <= 1'b1;
                sdo_oe_n <= 1'b1;
            end else if (two_wire || pin_mode[PM_DAT_OD]) begin
                sdo_out  <= 1'b0;
                sdo_oe_n <= drv_bit;
            end else begin
                sdo_out  <= drv_bit;
                sdo_oe_n <= 1'b0;
            end
        end
    end

    // chip select: output function only after a transfer has begun
    logic cs_out_fn;
    always_comb begin
        cs_out_fn = pin_mode[PM_MS] && pin_mode[PM_CSS_HI];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_started <= 1'b0;
            cs_n_out   <= 1'b1;
            cs_oe_n    <= 1'b1;
        end else if (ce) begin
            if (!cs_out_fn)
                cs_started <= 1'b0;
            else if (state == SSSP_SHIFT)
                cs_started <= 1'b1;
            if (cs_out_fn && state == SSSP_SHIFT) begin
                cs_n_out <= 1'b0;
                cs_oe_n  <= 1'b0;
            end else if (cs_out_fn && cs_started
                         && !pin_mode[PM_CS_OD]) begin
                cs_n_out <= 1'b1;
                cs_oe_n  <= 1'b0;
            end else begin
                cs_n_out <= 1'b1;
                cs_oe_n  <= 1'b1;
            end
        end
    end

    // pad configuration outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_port_mode   <= 1'b1;
            cs_input_mode  <= 1'b0;
            clk_port_mode  <= 1'b1;
            clk_open_drain <= 1'b0;
        end else if (ce) begin
            cs_port_mode   <= !pin_mode[PM_MS]
                || pin_mode[PM_CSS_HI:PM_CSS_LO] == 2'h0;
            cs_input_mode  <= pin_mode[PM_MS]
                && pin_mode[PM_CSS_HI:PM_CSS_LO] == 2'h1;
            clk_port_mode  <= !pin_mode[PM_CLKSEL];
            clk_open_drain <= pin_mode[PM_CLK_OD];
        end
    end

    // checks
    chk_rx_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && rd_rx && !set_rx |=> !rx_full_flag)
        else $error("rx full not cleared by data read");
    chk_tx_write_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wr_tx && !set_tempty && !set_tx_end_flag
        |=> !tx_empty_flag && !tx_end_flag)
        else $error("tx flags not cleared by data write");
    chk_rx_set: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && set_rx |=> rx_full_flag && rx_data_reg == $past(rx_byte))
        else $error("received byte not captured");
    chk_flag_fall: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(no_ack_flag) |-> $past(wr_status) && $past(armed[ST_NO_ACK])
        && !$past(w_byte[ST_NO_ACK]))
        else $error("no-ack cleared without read and zero write");
    chk_nack_halt: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && set_nack |=> no_ack_flag && state == SSSP_IDLE)
        else $error("nack did not flag and halt");
    chk_arb_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && set_arb |=> arb_lost_overrun_flag && state == SSSP_IDLE)
        else $error("arbitration loss not flagged");
    chk_tx_end_flag_twi: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && at_last && two_wire && tx_dir && tx_empty_flag
        |=> tx_end_flag)
        else $error("tx end missing at ninth clock");
    chk_tempty_load: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && (load || reload) |=> tx_empty_flag && !tx_buf_full
        || $past(wr_tx))
        else $error("tx empty not set on buffer move");
    chk_cs_port: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !pin_mode[PM_MS] |=> cs_port_mode && cs_oe_n)
        else $error("chip select not a port in sync mode");
    chk_cs_input: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cs_out_fn && !cs_started && state == SSSP_IDLE
        |=> cs_oe_n)
        else $error("chip select driven before transfer");
    chk_bidir_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !pin_mode[PM_MS] && !two_wire |-> din == sy2[SY_SDI])
        else $error("bidir applied in sync mode");
endmodule

// ==== sim/sssp_link_model.sv ====
// far side of the serial link: drives clock and data, samples the line
// assumes the bench resolves the pulled-up data line into sda
module sssp_link_model (
    // link pins driven by the far side
    output logic      sck,
    output logic      sdi,
    output logic      pull_low,
    // resolved shared data line
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sck = 1'b0;
        sdi = 1'b1;
        pull_low = 1'b0;
    end
    // msb first, 80 ns bit time; clock rests low between frames
    task automatic frame(input int n, input logic [8:0] din,
                         input logic [8:0] pull, output logic [8:0] cap);
        cap = 9'h000;
        // keep pin edges clear of the aclk edges
        #3;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = din[i];
            pull_low = pull[i];
            #40;
            sck = 1'b1;
            cap[i] = sda;
            #40;
            sck = 1'b0;
        end
        // released line must not keep showing the last bit
        sdi = ~sdi;
        pull_low = 1'b0;
    endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench: register tests over the host bus, link frames
// assumes the link model above stands at the serial pins
module testbench
    import sssp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        sdo_out, sdo_oe_n, cs_n_out, cs_oe_n, sck, sdi, pull_low;
    logic [3:0]  pad, strb;
    logic [7:0]  d;
    logic [8:0]  cap;
    wire         sda;
    int          fails, n_compared;
    assign sda = ~((~sdo_oe_n & ~sdo_out) | pull_low);
    sssp_top sssp_top_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(strb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .sck_in(sck), .sdi_in(sdi), .sdo_in(sda), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n), .cs_n_in(1'b1), .cs_n_out(cs_n_out),
        .cs_oe_n(cs_oe_n), .cs_port_mode(pad[3]), .cs_input_mode(pad[2]),
        .clk_port_mode(pad[1]), .clk_open_drain(pad[0])
    );
    sssp_link_model sssp_link_model_inst (
        .sck(sck), .sdi(sdi), .pull_low(pull_low), .sda(sda)
    );
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] v,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) begin
            fails++;
            test_done();
        end
        chk({6'h0, bresp}, {6'h0, er}, "write response");
    endtask
    task automatic rd(input logic [9:0] idx, output logic [7:0] v,
                      output logic [1:0] rr);
        int n;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        v = rdata[7:0];
        rr = rresp;
        if (n == 50) begin
            fails++;
            test_done();
        end
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
        rd(idx, d, r);
        chk(d, e, "read data");
    endtask
    // pad outputs lag their register by one cycle
    task automatic pads(input logic [5:0] e);
        repeat (2) @(posedge aclk);
        chk({2'h0, cs_n_out, cs_oe_n, pad}, {2'h0, e}, "pad config");
    endtask
    task automatic link(input int n, input logic [8:0] din,
                        input logic [8:0] pull);
        repeat (4) @(posedge aclk);
        sssp_link_model_inst.frame(n, din, pull, cap);
        repeat (8) @(posedge aclk);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        strb = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        pads(6'h3a);
        rdc(IDX_PIN_MODE, 8'h00);
        rdc(IDX_STATUS, 8'h00);
        wr(10'h000, 8'h55, RESP_SLVERR);
        rd(10'h001, d, r);
        chk({6'h0, r}, {6'h0, RESP_SLVERR}, "unmapped read");
        $display("test registers done");
        wr(IDX_PIN_MODE, 8'h01, RESP_OKAY);
        wr(IDX_PIN_MODE, 8'h03, RESP_OKAY);
        wr(IDX_PIN_MODE, 8'h13, RESP_OKAY);
        pads(6'h36);
        wr(IDX_PIN_MODE, 8'h03, RESP_OKAY);
        wr(IDX_PIN_MODE, 8'h23, RESP_OKAY);
        pads(6'h32);
        wr(IDX_PIN_MODE, 8'h2b, RESP_OKAY);
        wr(IDX_PIN_MODE, 8'h6b, RESP_OKAY);
        pads(6'h31);
        wr(IDX_PIN_MODE, 8'h6a, RESP_OKAY);
        pads(6'h39);
        rdc(IDX_PIN_MODE, 8'h6a);
        // byte lane 0 not strobed: write ignored, still okay
        strb <= 4'h0;
        wr(IDX_PIN_MODE, 8'h00, RESP_OKAY);
        strb <= 4'hf;
        rdc(IDX_PIN_MODE, 8'h6a);
        $display("test pin mode done");
        wr(IDX_CTRL, 8'h02, RESP_OKAY);
        rdc(IDX_STATUS, 8'h80);
        wr(IDX_TX_DATA, 8'ha5, RESP_OKAY);
        link(8, 9'h000, 9'h000);
        chk(cap[7:0], 8'ha5, "sent byte");
        rdc(IDX_STATUS, 8'hc0);
        wr(IDX_TX_DATA, 8'h5a, RESP_OKAY);
        rdc(IDX_STATUS, 8'h80);
        wr(IDX_STATUS, 8'hff, RESP_OKAY);
        rdc(IDX_STATUS, 8'h80);
        wr(IDX_STATUS, 8'h00, RESP_OKAY);
        rdc(IDX_STATUS, 8'h00);
        link(8, 9'h000, 9'h000);
        chk(cap[7:0], 8'h5a, "sent byte");
        rdc(IDX_STATUS, 8'h00);
        $display("test sync transmit done");
        wr(IDX_PIN_MODE, 8'hea, RESP_OKAY);
        wr(IDX_CTRL, 8'h00, RESP_OKAY);
        link(8, 9'h03c, 9'h000);
        rdc(IDX_STATUS, 8'h20);
        rdc(IDX_RX_DATA, 8'h3c);
        rdc(IDX_STATUS, 8'h00);
        $display("test sync receive done");
        wr(IDX_PIN_MODE, 8'h6a, RESP_OKAY);
        wr(IDX_CTRL, 8'h07, RESP_OKAY);
        wr(IDX_TX_DATA, 8'hc3, RESP_OKAY);
        link(9, 9'h000, 9'h000);
        chk(cap[8:1], 8'hc3, "sent byte");
        rdc(IDX_STATUS, 8'hd0);
        wr(IDX_STATUS, 8'h00, RESP_OKAY);
        wr(IDX_CTRL, 8'h03, RESP_OKAY);
        wr(IDX_TX_DATA, 8'h81, RESP_OKAY);
        link(9, 9'h000, 9'h000);
        rdc(IDX_STATUS, 8'hc0);
        $display("test two-wire ack done");
        wr(IDX_STATUS, 8'h00, RESP_OKAY);
        wr(IDX_CTRL, 8'h0b, RESP_OKAY);
        wr(IDX_TX_DATA, 8'hff, RESP_OKAY);
        link(9, 9'h000, 9'h100);
        rdc(IDX_STATUS, 8'h84);
        wr(IDX_STATUS, 8'h00, RESP_OKAY);
        rdc(IDX_STATUS, 8'h00);
        wr(IDX_CTRL, 8'h11, RESP_OKAY);
        rdc(IDX_STATUS, 8'h80);
        $display("test arbitration and start done");
        wr(IDX_CTRL, 8'h02, RESP_OKAY);
        wr(IDX_PIN_MODE, 8'h6b, RESP_OKAY);
        wr(IDX_TX_DATA, 8'h96, RESP_OKAY);
        pads(6'h01);
        link(8, 9'h000, 9'h000);
        chk(cap[7:0], 8'h96, "sent byte");
        rdc(IDX_STATUS, 8'hc0);
        pads(6'h31);
        $display("test four-wire chip select done");
        test_done();
    end
endmodule
